//--- bkm_pkg.sv
package bkm_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [15:0] OFS_BREAK_STATUS = 16'hFE00;
    localparam logic [15:0] OFS_BREAK_FLAG_CONTROL = 16'hFE03;
    localparam logic [15:0] OFS_BREAK_ADDRESS_HIGH = 16'hFE09;
    localparam logic [15:0] OFS_BREAK_ADDRESS_LOW = 16'hFE0A;
    localparam logic [15:0] OFS_BREAK_STATUS_CONTROL = 16'hFE0B;
    localparam logic [15:0] OFS_IRQ_STATUS = 16'hFE1C;
    localparam logic [15:0] OFS_IRQ_ENABLE = 16'hFE1D;
    localparam logic [15:0] OFS_IRQ_CLEAR = 16'hFE1E;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int BIT_STOP_WAIT_BREAK_FLAG = 1;
    localparam int BIT_BREAK_FLAG_CLEAR_ENABLE = 7;
    localparam int BIT_BREAK_MATCH_ENABLE = 7;
    localparam int BIT_BREAK_ACTIVE = 6;
    localparam int BIT_EV_BREAK_ENTRY = 0;
    localparam int BIT_EV_WAIT_BREAK = 1;
    localparam int NUM_EVENTS = 2;

    // ---------------------------------------------------------------
    // reset values and vectors
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_ADDR = 16'h0000;
    localparam logic [15:0] VEC_BREAK_NORMAL = 16'hFFFC;
    localparam logic [15:0] VEC_BREAK_MONITOR = 16'hFEFC;

    typedef struct packed {
        logic flag_clear_allow;
        logic timer_halt;
        logic capture_inhibit;
        logic watchdog_disable;
    } bkm_side_t;

    localparam bkm_side_t RST_SIDE = '{flag_clear_allow: 1'b1, timer_halt: 1'b0,
                                       capture_inhibit: 1'b0, watchdog_disable: 1'b0};
endpackage

//--- bkm_addr_match.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// full 16-bit compare of the program address
// ---------------------------------------------------------------
module bkm_addr_match (
    input wire logic [15:0] cpu_addr_in, // program counter address
    input wire logic [15:0] break_addr_in, // programmed breakpoint
    input wire logic valid_in, // address is a real fetch
    input wire logic enable_in, // match enable and armed
    output logic hit_out // address match
);
    always_comb begin
        hit_out = valid_in && enable_in && (cpu_addr_in == break_addr_in);
    end
endmodule

//--- bkm_irq_ctrl.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// sticky event status, enable mask and level interrupt
// ---------------------------------------------------------------
module bkm_irq_ctrl (
    input wire logic clk_in, // core clock
    input wire logic arst_n_in, // async reset, active low
    input wire logic [bkm_pkg::NUM_EVENTS-1:0] event_in, // one-cycle event pulses
    input wire logic enable_wr_in, // write to enable register
    input wire logic clear_wr_in, // write to clear register
    input wire logic [bkm_pkg::NUM_EVENTS-1:0] wdata_in, // write data
    output logic [bkm_pkg::NUM_EVENTS-1:0] status_out, // sticky status
    output logic [bkm_pkg::NUM_EVENTS-1:0] enable_out, // enable mask
    output logic irq_out // level interrupt
);
    logic [bkm_pkg::NUM_EVENTS-1:0] status_ff;
    logic [bkm_pkg::NUM_EVENTS-1:0] enable_ff;
    logic irq_ff;
    logic [bkm_pkg::NUM_EVENTS-1:0] nxt_status;

    // set beats clear so no event is lost
    always_comb begin
        nxt_status = status_ff;
        if (clear_wr_in) begin
            nxt_status = status_ff & ~wdata_in;
        end
        nxt_status = nxt_status | event_in;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            status_ff <= '0;
            enable_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            if (enable_wr_in) begin
                enable_ff <= wdata_in;
            end
            irq_ff <= |(nxt_status & (enable_wr_in ? wdata_in : enable_ff));
        end
    end

    assign status_out = status_ff;
    assign enable_out = enable_ff;
    assign irq_out = irq_ff;
endmodule

//--- bkm_break_top.sv
`timescale 1ns/1ps
module bkm_break_top (
    input wire logic CORE_CLK_IN, // core clock
    input wire logic ARST_N_IN, // async reset, active low
    input wire logic [15:0] REG_ADDR_IN, // register address
    input wire logic [7:0] REG_WDATA_IN, // register write data
    input wire logic REG_WR_IN, // write strobe
    input wire logic REG_RD_IN, // read strobe
    output logic [7:0] REG_RDATA_OUT, // read data, cycle after strobe
    input wire logic [15:0] CPU_ADDR_IN, // program counter address
    input wire logic CPU_ADDR_VALID_IN, // address is a fetch
    input wire logic CPU_OPCODE_FETCH_IN, // fetch is an opcode
    input wire logic CPU_INSTR_START_IN, // next instruction about to begin
    input wire logic CPU_RTI_DONE_IN, // return_from_interrupt completed
    input wire logic CPU_WAIT_MODE_IN, // core in wait mode
    input wire logic CPU_STOP_MODE_IN, // core in stop mode
    input wire logic MONITOR_MODE_IN, // monitor_unit mode active
    input wire logic TEST_VOLTAGE_IN, // test_voltage on reset pin
    output logic BREAKPOINT_REQUEST_OUT, // one-cycle request to integration unit
    output logic FORCE_SWI_OUT, // load software_interrupt_instruction
    output logic [15:0] VECTOR_ADDR_OUT, // break vector high byte address
    output logic BREAK_STATE_OUT, // break in progress
    output logic FLAG_CLEAR_ALLOW_OUT, // module flags may be cleared
    output logic TIMER_HALT_OUT, // timer_unit counter halt
    output logic CAPTURE_INHIBIT_OUT, // timer_unit input capture ignore
    output logic WATCHDOG_DISABLE_OUT, // watchdog_unit hold off
    output logic IRQ_OUT // level interrupt
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [7:0] break_address_high_ff;
    logic [7:0] break_address_low_ff;
    logic break_match_enable_ff;
    logic break_active_ff;
    logic stop_wait_break_flag_ff;
    logic break_flag_clear_enable_ff;
    logic armed_ff;
    logic pending_ff;
    logic break_state_ff;
    logic request_ff;
    logic [15:0] vector_ff;
    bkm_pkg::bkm_side_t side_ff;
    logic [7:0] rdata_ff;

    logic nxt_break_active;
    logic nxt_break_state;
    logic nxt_stop_wait;
    logic nxt_pending;
    logic nxt_armed;
    bkm_pkg::bkm_side_t nxt_side;
    logic [7:0] nxt_rdata;

    logic addr_hit;
    logic opcode_hit;
    logic operand_hit;
    logic sw_force;
    logic take;
    logic wr_status_ctrl;
    logic wr_addr_hi;
    logic wr_addr_lo;
    logic [bkm_pkg::NUM_EVENTS-1:0] events;
    logic [bkm_pkg::NUM_EVENTS-1:0] irq_status;
    logic [bkm_pkg::NUM_EVENTS-1:0] irq_enable;
    logic irq;

    typedef enum logic [1:0] {
        BKM_IDLE,
        BKM_WAIT_BOUNDARY,
        BKM_IN_BREAK
    } bkm_phase_t;
    bkm_phase_t phase;

    function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs, input logic strobe);
        hit = strobe && (addr == ofs);
    endfunction

    // ---------------------------------------------------------------
    // address compare
    // ---------------------------------------------------------------
    // stop mode blocks only the address compare; a software break still sets pending
    bkm_addr_match u_match (
        .cpu_addr_in(CPU_ADDR_IN),
        .break_addr_in({break_address_high_ff, break_address_low_ff}),
        .valid_in(CPU_ADDR_VALID_IN && !CPU_STOP_MODE_IN),
        .enable_in(break_match_enable_ff && armed_ff && !break_state_ff),
        .hit_out(addr_hit)
    );

    assign wr_status_ctrl = hit(REG_ADDR_IN, bkm_pkg::OFS_BREAK_STATUS_CONTROL, REG_WR_IN);
    assign wr_addr_hi = hit(REG_ADDR_IN, bkm_pkg::OFS_BREAK_ADDRESS_HIGH, REG_WR_IN);
    assign wr_addr_lo = hit(REG_ADDR_IN, bkm_pkg::OFS_BREAK_ADDRESS_LOW, REG_WR_IN);
    assign sw_force = wr_status_ctrl && REG_WDATA_IN[bkm_pkg::BIT_BREAK_ACTIVE] && !break_state_ff;
    assign opcode_hit = addr_hit && CPU_OPCODE_FETCH_IN;
    assign operand_hit = addr_hit && !CPU_OPCODE_FETCH_IN;

    // opcode hit replaces the fetched opcode now; others wait for the boundary
    assign take = !break_state_ff && (opcode_hit || (pending_ff && CPU_INSTR_START_IN));

    // ---------------------------------------------------------------
    // break sequencing
    // ---------------------------------------------------------------
    always_comb begin
        nxt_pending = pending_ff;
        if (take) begin
            nxt_pending = 1'b0;
        end else if (operand_hit || sw_force) begin
            nxt_pending = 1'b1;
        end
    end

    always_comb begin
        nxt_break_state = break_state_ff;
        if (take) begin
            nxt_break_state = 1'b1;
        end else if (break_state_ff && CPU_RTI_DONE_IN) begin
            nxt_break_state = 1'b0;
        end
    end

    // a taken match disarms until a new address is loaded
    always_comb begin
        nxt_armed = armed_ff;
        if (wr_addr_hi || wr_addr_lo) begin
            nxt_armed = 1'b1;
        end else if (addr_hit) begin
            nxt_armed = 1'b0;
        end
    end

    always_comb begin
        nxt_break_active = break_active_ff;
        if (wr_status_ctrl) begin
            nxt_break_active = REG_WDATA_IN[bkm_pkg::BIT_BREAK_ACTIVE];
        end
        if (addr_hit) begin
            nxt_break_active = 1'b1;
        end
    end

    always_comb begin
        nxt_stop_wait = stop_wait_break_flag_ff;
        if (hit(REG_ADDR_IN, bkm_pkg::OFS_BREAK_STATUS, REG_WR_IN) &&
            !REG_WDATA_IN[bkm_pkg::BIT_STOP_WAIT_BREAK_FLAG]) begin
            nxt_stop_wait = 1'b0;
        end
        if (take && CPU_WAIT_MODE_IN) begin
            nxt_stop_wait = 1'b1;
        end
    end

    always_comb begin
        nxt_side.flag_clear_allow = !nxt_break_state || break_flag_clear_enable_ff;
        nxt_side.timer_halt = nxt_break_state;
        nxt_side.capture_inhibit = nxt_break_state;
        nxt_side.watchdog_disable = nxt_break_state && TEST_VOLTAGE_IN;
    end

    always_comb begin
        case ({break_state_ff, pending_ff})
            2'b00: phase = BKM_IDLE;
            2'b01: phase = BKM_WAIT_BOUNDARY;
            default: phase = BKM_IN_BREAK;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            pending_ff <= 1'b0;
            break_state_ff <= 1'b0;
            armed_ff <= 1'b1;
        end else begin
            pending_ff <= nxt_pending;
            break_state_ff <= nxt_break_state;
            armed_ff <= nxt_armed;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            request_ff <= 1'b0;
            vector_ff <= bkm_pkg::VEC_BREAK_NORMAL;
        end else begin
            request_ff <= take;
            if (take) begin
                vector_ff <= MONITOR_MODE_IN ? bkm_pkg::VEC_BREAK_MONITOR : bkm_pkg::VEC_BREAK_NORMAL;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            side_ff <= bkm_pkg::RST_SIDE;
        end else begin
            side_ff <= nxt_side;
        end
    end

    // ---------------------------------------------------------------
    // software registers
    // ---------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            break_address_high_ff <= bkm_pkg::RST_BYTE;
            break_address_low_ff <= bkm_pkg::RST_BYTE;
        end else begin
            if (wr_addr_hi) begin
                break_address_high_ff <= REG_WDATA_IN;
            end
            if (wr_addr_lo) begin
                break_address_low_ff <= REG_WDATA_IN;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            break_match_enable_ff <= 1'b0;
            break_active_ff <= 1'b0;
            stop_wait_break_flag_ff <= 1'b0;
            break_flag_clear_enable_ff <= 1'b0;
        end else begin
            if (wr_status_ctrl) begin
                break_match_enable_ff <= REG_WDATA_IN[bkm_pkg::BIT_BREAK_MATCH_ENABLE];
            end
            if (hit(REG_ADDR_IN, bkm_pkg::OFS_BREAK_FLAG_CONTROL, REG_WR_IN)) begin
                break_flag_clear_enable_ff <= REG_WDATA_IN[bkm_pkg::BIT_BREAK_FLAG_CLEAR_ENABLE];
            end
            break_active_ff <= nxt_break_active;
            stop_wait_break_flag_ff <= nxt_stop_wait;
        end
    end

    // ---------------------------------------------------------------
    // interrupt
    // ---------------------------------------------------------------
    assign events = {take && CPU_WAIT_MODE_IN, take};

    bkm_irq_ctrl u_irq (
        .clk_in(CORE_CLK_IN),
        .arst_n_in(ARST_N_IN),
        .event_in(events),
        .enable_wr_in(hit(REG_ADDR_IN, bkm_pkg::OFS_IRQ_ENABLE, REG_WR_IN)),
        .clear_wr_in(hit(REG_ADDR_IN, bkm_pkg::OFS_IRQ_CLEAR, REG_WR_IN)),
        .wdata_in(REG_WDATA_IN[bkm_pkg::NUM_EVENTS-1:0]),
        .status_out(irq_status),
        .enable_out(irq_enable),
        .irq_out(irq)
    );

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    // reserved bits and unmapped addresses read zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                bkm_pkg::OFS_BREAK_STATUS:
                    nxt_rdata[bkm_pkg::BIT_STOP_WAIT_BREAK_FLAG] = stop_wait_break_flag_ff;
                bkm_pkg::OFS_BREAK_FLAG_CONTROL:
                    nxt_rdata[bkm_pkg::BIT_BREAK_FLAG_CLEAR_ENABLE] = break_flag_clear_enable_ff;
                bkm_pkg::OFS_BREAK_ADDRESS_HIGH: nxt_rdata = break_address_high_ff;
                bkm_pkg::OFS_BREAK_ADDRESS_LOW: nxt_rdata = break_address_low_ff;
                bkm_pkg::OFS_BREAK_STATUS_CONTROL: begin
                    nxt_rdata[bkm_pkg::BIT_BREAK_MATCH_ENABLE] = break_match_enable_ff;
                    nxt_rdata[bkm_pkg::BIT_BREAK_ACTIVE] = break_active_ff;
                end
                bkm_pkg::OFS_IRQ_STATUS: nxt_rdata[bkm_pkg::NUM_EVENTS-1:0] = irq_status;
                bkm_pkg::OFS_IRQ_ENABLE: nxt_rdata[bkm_pkg::NUM_EVENTS-1:0] = irq_enable;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign REG_RDATA_OUT = rdata_ff;
    assign BREAKPOINT_REQUEST_OUT = request_ff;
    assign FORCE_SWI_OUT = request_ff;
    assign VECTOR_ADDR_OUT = vector_ff;
    assign BREAK_STATE_OUT = break_state_ff;
    assign FLAG_CLEAR_ALLOW_OUT = side_ff.flag_clear_allow;
    assign TIMER_HALT_OUT = side_ff.timer_halt;
    assign CAPTURE_INHIBIT_OUT = side_ff.capture_inhibit;
    assign WATCHDOG_DISABLE_OUT = side_ff.watchdog_disable;
    assign IRQ_OUT = irq;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_opcode_break;
        @(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        opcode_hit && (phase != BKM_IN_BREAK) |=> BREAKPOINT_REQUEST_OUT && BREAK_STATE_OUT;
    endproperty
    a_opcode_break: assert property (p_opcode_break) else $error("opcode match not taken");

    property p_vector;
        @(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        BREAKPOINT_REQUEST_OUT |-> VECTOR_ADDR_OUT ==
            ($past(MONITOR_MODE_IN) ? bkm_pkg::VEC_BREAK_MONITOR : bkm_pkg::VEC_BREAK_NORMAL);
    endproperty
    a_vector: assert property (p_vector) else $error("wrong break vector");

    property p_operand_waits;
        @(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        operand_hit && !break_state_ff ##1 (!CPU_INSTR_START_IN && !opcode_hit) |=> !BREAKPOINT_REQUEST_OUT;
    endproperty
    a_operand_waits: assert property (p_operand_waits) else $error("operand break too early");

    property p_sw_force;
        @(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        sw_force ##1 CPU_INSTR_START_IN |=> BREAKPOINT_REQUEST_OUT;
    endproperty
    a_sw_force: assert property (p_sw_force) else $error("software break not taken");

    property p_rti_ends;
        @(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        BREAK_STATE_OUT && CPU_RTI_DONE_IN |=> !BREAK_STATE_OUT ##1 !TIMER_HALT_OUT;
    endproperty
    a_rti_ends: assert property (p_rti_ends) else $error("break state not ended");

    property p_no_rebreak;
        @(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        addr_hit ##1 (!wr_addr_hi && !wr_addr_lo) [*2] |=> !armed_ff;
    endproperty
    a_no_rebreak: assert property (p_no_rebreak) else $error("rearmed without new address");

    property p_flag_protect;
        @(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        BREAK_STATE_OUT && !break_flag_clear_enable_ff && !$past(break_flag_clear_enable_ff) |-> !FLAG_CLEAR_ALLOW_OUT;
    endproperty
    a_flag_protect: assert property (p_flag_protect) else $error("flag clear allowed in break");

    property p_timer_halt;
        @(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        $rose(BREAK_STATE_OUT) |-> TIMER_HALT_OUT && CAPTURE_INHIBIT_OUT;
    endproperty
    a_timer_halt: assert property (p_timer_halt) else $error("timer not halted");

    property p_watchdog;
        @(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        nxt_break_state && TEST_VOLTAGE_IN |=> WATCHDOG_DISABLE_OUT;
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog not disabled");

    property p_wait_flag;
        @(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        take && CPU_WAIT_MODE_IN ##1 !hit(REG_ADDR_IN, bkm_pkg::OFS_BREAK_STATUS, REG_WR_IN) |->
            stop_wait_break_flag_ff ##1 stop_wait_break_flag_ff;
    endproperty
    a_wait_flag: assert property (p_wait_flag) else $error("wait flag lost");

    property p_match_enable;
        @(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        !break_match_enable_ff |-> !addr_hit;
    endproperty
    a_match_enable: assert property (p_match_enable) else $error("match while disabled");
endmodule

//--- bkm_cpu_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// cpu core and integration unit stand-in
// ---------------------------------------------------------------
module bkm_cpu_model (
    input wire logic clk_in, // core clock
    input wire logic force_swi_in, // swi load request
    input wire logic [7:0] rti_delay_in, // break routine length
    output logic [15:0] addr_out, // program address
    output logic valid_out, // fetch qualifier
    output logic opcode_out, // opcode or operand
    output logic start_out, // instruction boundary
    output logic rti_out // return done
);
    initial begin
        addr_out = 16'h0000;
        valid_out = 1'b0;
        opcode_out = 1'b0;
        start_out = 1'b0;
        rti_out = 1'b0;
    end

    // break routine runs, then returns
    always @(posedge clk_in) begin
        if (force_swi_in === 1'b1) begin
            repeat (rti_delay_in) @(posedge clk_in);
            rti_out <= 1'b1;
            @(posedge clk_in);
            rti_out <= 1'b0;
        end
    end

    task automatic fetch(input logic [15:0] a, input logic op);
        @(posedge clk_in);
        addr_out <= a;
        valid_out <= 1'b1;
        opcode_out <= op;
        @(posedge clk_in);
        valid_out <= 1'b0;
        addr_out <= ~a; // idle bus must not repeat a stale match
    endtask

    task automatic boundary();
        @(posedge clk_in);
        start_out <= 1'b1;
        @(posedge clk_in);
        start_out <= 1'b0;
    endtask
endmodule

//--- bkm_break_top_tb_top.sv
`timescale 1ns/1ps
module bkm_break_top_tb_top;
    logic clk, arst_n, wr, rd, wmode, mon, tv, req, software_interrupt_instruction, brk, fca, th, ci, wd, irq;
    logic [15:0] addr, vec, caddr;
    logic [7:0] wdata, rdata, dly;
    logic cval, watchdog_unit, cst, crti;
    int n_fail = 0;
    int n_compared = 0;

    bkm_cpu_model cpu (.clk_in(clk), .force_swi_in(software_interrupt_instruction), .rti_delay_in(dly), .addr_out(caddr),
        .valid_out(cval), .opcode_out(watchdog_unit), .start_out(cst), .rti_out(crti));
    bkm_break_top DUT (.CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .CPU_ADDR_IN(caddr),
        .CPU_ADDR_VALID_IN(cval), .CPU_OPCODE_FETCH_IN(watchdog_unit), .CPU_INSTR_START_IN(cst),
        .CPU_RTI_DONE_IN(crti), .CPU_WAIT_MODE_IN(wmode), .CPU_STOP_MODE_IN(1'b0),
        .MONITOR_MODE_IN(mon), .TEST_VOLTAGE_IN(tv), .BREAKPOINT_REQUEST_OUT(req),
        .FORCE_SWI_OUT(software_interrupt_instruction), .VECTOR_ADDR_OUT(vec), .BREAK_STATE_OUT(brk),
        .FLAG_CLEAR_ALLOW_OUT(fca), .TIMER_HALT_OUT(th), .CAPTURE_INHIBIT_OUT(ci),
        .WATCHDOG_DISABLE_OUT(wd), .IRQ_OUT(irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg_%h", a), {8'h00, exp}, {8'h00, rdata});
    endtask

    // idle=1: wait for break end, else for the request
    task automatic wait_for(input bit idle, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            #1;
            if (idle ? (brk === 1'b0) : (req === 1'b1)) break;
            @(posedge clk);
        end
        if (i == lim) begin
            chk("wait_bound", 16'h0001, 16'h0000);
            complete_run();
        end
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic sc_reset();
        chk("vector", 16'hFFFC, vec);
        chk("sides", 16'h0008, {12'h000, fca, th, ci, wd});
        rd_reg(16'hFE09, 8'h00);
        rd_reg(16'hFE0A, 8'h00);
        rd_reg(16'hFE0B, 8'h00);
        rd_reg(16'hFE03, 8'h00);
        rd_reg(16'hFE00, 8'h00);
    endtask

    task automatic sc_opcode();
        wr_reg(16'hFE0A, 8'h34);
        cpu.fetch(16'h1234, 1'b1);
        #1;
        chk("request_off", 16'h0000, {15'h0, req});
        wr_reg(16'hFE0B, 8'h80);
        cpu.fetch(16'h1234, 1'b1);
        #1;
        chk("partial_addr", 16'h0000, {15'h0, req});
        wr_reg(16'hFE09, 8'h12);
        cpu.fetch(16'h1234, 1'b1);
        #1;
        chk("request", 16'h0003, {14'h0, req, software_interrupt_instruction});
        chk("vector", 16'hFFFC, vec);
        chk("sides", 16'h0007, {12'h000, fca, th, ci, wd});
        @(posedge clk);
        #1;
        chk("request_end", 16'h0000, {15'h0, req});
        rd_reg(16'hFE0B, 8'hC0);
        wr_reg(16'hFE0B, 8'h80);
        rd_reg(16'hFE0B, 8'h80);
        wait_for(1'b1, 40);
        chk("sides_back", 16'h0008, {12'h000, fca, th, ci, wd});
    endtask

    task automatic sc_rebreak();
        cpu.fetch(16'h1234, 1'b1);
        #1;
        chk("no_rebreak", 16'h0000, {15'h0, req});
        mon <= 1'b1;
        tv <= 1'b0;
        wr_reg(16'hFE03, 8'h80);
        wr_reg(16'hFE0A, 8'h34);
        cpu.fetch(16'h1234, 1'b1);
        #1;
        chk("rebreak", 16'h0001, {15'h0, req});
        chk("vector_mon", 16'hFEFC, vec);
        chk("sides_break_flag_clear_enable", 16'h000E, {12'h000, fca, th, ci, wd});
        wait_for(1'b1, 40);
        mon <= 1'b0;
        wr_reg(16'hFE03, 8'h00);
    endtask

    task automatic sc_operand();
        wr_reg(16'hFE0A, 8'h56);
        cpu.fetch(16'h1256, 1'b0);
        #1;
        chk("operand_hold", 16'h0000, {15'h0, req});
        cpu.boundary();
        wait_for(1'b0, 2);
        wait_for(1'b1, 40);
    endtask

    task automatic sc_soft();
        wmode <= 1'b1;
        dly <= 8'h01;
        wr_reg(16'hFE0B, 8'hC0);
        #1;
        chk("soft_hold", 16'h0000, {15'h0, req});
        cpu.boundary();
        wait_for(1'b0, 2);
        wait_for(1'b1, 40);
        wmode <= 1'b0;
        rd_reg(16'hFE00, 8'h02);
        wr_reg(16'hFE00, 8'h02);
        rd_reg(16'hFE00, 8'h02);
        wr_reg(16'hFE00, 8'h00);
        rd_reg(16'hFE00, 8'h00);
    endtask

    task automatic sc_irq();
        rd_reg(16'hFE1C, 8'h03);
        wr_reg(16'hFE1D, 8'h01);
        @(posedge clk);
        #1;
        chk("irq_on", 16'h0001, {15'h0, irq});
        wr_reg(16'hFE1E, 8'h01);
        rd_reg(16'hFE1C, 8'h02);
        chk("irq_masked", 16'h0000, {15'h0, irq});
        wr_reg(16'hFE02, 8'hFF);
        rd_reg(16'hFE02, 8'h00);
    endtask

    initial begin
        arst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 16'h0000;
        wdata = 8'h00;
        wmode = 1'b0;
        mon = 1'b0;
        tv = 1'b1;
        dly = 8'h08;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        sc_reset();
        sc_opcode();
        sc_rebreak();
        sc_operand();
        sc_soft();
        sc_irq();
        complete_run();
    end
endmodule
